// ### hdl/srwdg_cfg.svh
/*
 * timing and option constants for the reset supervisor with watchdog.
 * assumes a single 50 MHz timebase (20 ns period).
 */
`ifndef SRWDG_CFG_SVH
`define SRWDG_CFG_SVH

// ----------------------------------------
// timebase
// ----------------------------------------
`define SRWDG_CLK_PERIOD_NS   20
`define SRWDG_CLK_HZ          50000000

// ----------------------------------------
// reset hold period
// ----------------------------------------
`define SRWDG_HOLD_MS         200
`define SRWDG_HOLD_CYC        ((`SRWDG_HOLD_MS * (`SRWDG_CLK_HZ / 1000)))

// ----------------------------------------
// watchdog timeout and minimum kick pulse
// ----------------------------------------
`define SRWDG_WD_TIMEOUT_MS   1600
`define SRWDG_WD_TIMEOUT_CYC  ((`SRWDG_WD_TIMEOUT_MS * (`SRWDG_CLK_HZ / 1000)))
`define SRWDG_KICK_MIN_NS     50
`define SRWDG_KICK_MIN_CYC    ((`SRWDG_KICK_MIN_NS + `SRWDG_CLK_PERIOD_NS - 1) / `SRWDG_CLK_PERIOD_NS)
`define SRWDG_SVC_LEN_CYC     4

// ----------------------------------------
// manual reset debounce time
// ----------------------------------------
`define SRWDG_DEBOUNCE_US     1000
`define SRWDG_DEBOUNCE_CYC    ((`SRWDG_DEBOUNCE_US * (`SRWDG_CLK_HZ / 1000000)))

`endif

// ### hdl/srwdg_pkg.sv
/*
 * types for the reset supervisor with watchdog.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package srwdg_pkg;
	typedef enum logic [1:0] {
		RST_CAUSE,
		RST_HOLD,
		RST_RUN
	} srwdg_state_e;
endpackage : srwdg_pkg

// ### hdl/srwdg_sync.sv
/*
 * two-flop synchroniser with a counting filter behind it.
 * assumes CLOCK is the single timebase and RESET is synchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none

module srwdg_sync #(
	parameter int unsigned FILT_CYC = 1,
	parameter logic        INIT     = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// raw and cleaned level
	input  wire logic din,
	output var  logic dout
);
	localparam int unsigned W = (FILT_CYC < 2) ? 1 : $clog2(FILT_CYC + 1);

	logic         s1_reg;
	logic         s2_reg;
	logic [W-1:0] cnt_reg;

	// first flop feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
		end
	end

	// output follows only after the new level has been stable FILT_CYC cycles
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
			dout    <= INIT;
		end else if (s2_reg == dout) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= W'(FILT_CYC - 1)) begin
			cnt_reg <= '0;
			dout    <= s2_reg;
		end else begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end
endmodule : srwdg_sync

`default_nettype wire

// ### hdl/srwdg_top.sv
/*
 * reset supervisor: supply-low, manual push-button and watchdog causes
 * drive a reset that is held for a fixed period after every cause ends.
 * assumes a 50 MHz CLOCK, a synchronous RESET standing for power-on,
 * and supply-low delivered as a digital level by an analog comparator.
 */
`timescale 1ns/1ps
`default_nettype none
`include "srwdg_cfg.svh"

// Summary of operation
// - hold reset for hold period after supply good
// - supply low clears the hold timer
// - every reset lasts at least hold period
// - manual low resets, then hold period after
// - unconnected manual input reads high, inactive
// - manual input debounced, one reset per press
// - kick stuck for timeout asserts reset
// - watchdog expiry followed by full hold period
// - kick edges and reset clear watchdog timer
// - kick pulses of 50 ns are seen
// - watchdog held cleared while reset asserted
// - internal chain pulses unconnected kick input
// - active-high reset is inverse of active-low
// - open-drain output sinks only during reset
module srwdg_top #(
	parameter bit          HAS_WATCHDOG  = 1'b1,
	parameter bit          HAS_MANUAL    = 1'b1,
	parameter bit          HAS_RST_N     = 1'b1,
	parameter bit          HAS_RST_HIGH  = 1'b1,
	parameter bit          OPEN_DRAIN    = 1'b0,
	parameter int unsigned HOLD_CYC      = `SRWDG_HOLD_CYC,
	parameter int unsigned WD_CYC        = `SRWDG_WD_TIMEOUT_CYC,
	parameter int unsigned DEBOUNCE_CYC  = `SRWDG_DEBOUNCE_CYC
) (
	// clock and power-on reset
	input  wire logic CLOCK,
	input  wire logic RESET,
	// reset causes
	input  wire logic SUPPLY_LOW,
	input  wire logic MANUAL_RESET_N,
	input  wire logic MANUAL_RESET_N_OE,
	input  wire logic WATCHDOG_KICK,
	input  wire logic WATCHDOG_KICK_OE,
	// internal counter-chain drive of the kick pin
	output var  logic WATCHDOG_KICK_DRV,
	output var  logic WATCHDOG_KICK_DRV_OE,
	// reset outputs
	output var  logic RESET_N_OUT,
	output var  logic RESET_N_OUT_OE,
	output var  logic RESET_HIGH_OUT
);
	localparam int unsigned HW = $clog2(HOLD_CYC + 1);
	localparam int unsigned WW = $clog2(WD_CYC + 1);
	// internal service pulse well inside the timeout, wide enough to be seen
	localparam int unsigned SVC_AT  = WD_CYC / 2;
	localparam int unsigned SVC_LEN = `SRWDG_SVC_LEN_CYC;

	// ----------------------------------------
	// pin resolution and synchronisers
	// ----------------------------------------
	logic man_pin;
	logic kick_pin;
	logic man_clean;
	logic kick_sync;
	logic kick_prev_reg;

	// undriven manual pin reads as its pull-up level
	assign man_pin  = (MANUAL_RESET_N_OE && HAS_MANUAL) ? MANUAL_RESET_N : 1'b1;
	// undriven kick pin follows the internal counter chain
	assign kick_pin = WATCHDOG_KICK_OE ? WATCHDOG_KICK
	                                   : (WATCHDOG_KICK_DRV_OE & WATCHDOG_KICK_DRV);

	// debounce filter swallows switch bounce: one clean press only
	srwdg_sync #(
		.FILT_CYC (DEBOUNCE_CYC),
		.INIT     (1'b1)
	) u_man_sync (
		.clk  (CLOCK),
		.rst  (RESET),
		.din  (man_pin),
		.dout (man_clean)
	);

	// no filter on kick: a 50 ns pulse spans at least two clock edges
	srwdg_sync #(
		.FILT_CYC (1),
		.INIT     (1'b0)
	) u_kick_sync (
		.clk  (CLOCK),
		.rst  (RESET),
		.din  (kick_pin),
		.dout (kick_sync)
	);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			kick_prev_reg <= 1'b0;
		end else begin
			kick_prev_reg <= kick_sync;
		end
	end

	logic kick_edge;
	assign kick_edge = kick_sync ^ kick_prev_reg;

	// ----------------------------------------
	// reset sequencer
	// ----------------------------------------
	srwdg_pkg::srwdg_state_e state_reg;
	logic [HW-1:0]           hold_reg;
	logic [WW-1:0]           wd_reg;
	logic                    cause_now;
	logic                    wd_expire;
	logic                    rst_active;

	assign cause_now  = SUPPLY_LOW | (HAS_MANUAL & ~man_clean);
	assign wd_expire  = HAS_WATCHDOG && (wd_reg >= WW'(WD_CYC - 1));
	assign rst_active = (state_reg != srwdg_pkg::RST_RUN);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state_reg <= srwdg_pkg::RST_CAUSE;
			hold_reg  <= '0;
		end else begin
			unique case (state_reg)
				srwdg_pkg::RST_CAUSE: begin
					hold_reg <= '0;
					if (!cause_now) begin
						state_reg <= srwdg_pkg::RST_HOLD;
					end
				end
				srwdg_pkg::RST_HOLD: begin
					if (cause_now) begin
						hold_reg  <= '0;
						state_reg <= srwdg_pkg::RST_CAUSE;
					end else if (hold_reg >= HW'(HOLD_CYC - 1)) begin
						hold_reg  <= '0;
						state_reg <= srwdg_pkg::RST_RUN;
					end else begin
						hold_reg <= hold_reg + HW'(1);
					end
				end
				srwdg_pkg::RST_RUN: begin
					hold_reg <= '0;
					if (cause_now) begin
						state_reg <= srwdg_pkg::RST_CAUSE;
					end else if (wd_expire) begin
						state_reg <= srwdg_pkg::RST_HOLD;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// watchdog timer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET || rst_active || kick_edge || wd_expire) begin
			wd_reg <= '0;
		end else begin
			wd_reg <= wd_reg + WW'(1);
		end
	end

	// ----------------------------------------
	// internal kick counter chain
	// ----------------------------------------
	// low-high-low pulse once per timeout; the free-running count is
	// separate so a floating pin never lets the timer reach expiry
	logic [WW-1:0] svc_reg;

	always_ff @(posedge CLOCK) begin
		if (RESET || svc_reg >= WW'(WD_CYC - 1)) begin
			svc_reg <= '0;
		end else begin
			svc_reg <= svc_reg + WW'(1);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			WATCHDOG_KICK_DRV    <= 1'b0;
			WATCHDOG_KICK_DRV_OE <= 1'b0;
		end else begin
			WATCHDOG_KICK_DRV    <= HAS_WATCHDOG && (svc_reg >= WW'(SVC_AT))
			                        && (svc_reg < WW'(SVC_AT + SVC_LEN));
			WATCHDOG_KICK_DRV_OE <= HAS_WATCHDOG && !WATCHDOG_KICK_OE;
		end
	end

	// ----------------------------------------
	// reset outputs
	// ----------------------------------------
	logic assert_next;
	assign assert_next = RESET || cause_now || (state_reg != srwdg_pkg::RST_RUN && !(
	                     state_reg == srwdg_pkg::RST_HOLD && hold_reg >= HW'(HOLD_CYC - 1)))
	                     || wd_expire;

	always_ff @(posedge CLOCK) begin
		RESET_N_OUT    <= HAS_RST_N ? (OPEN_DRAIN ? 1'b0 : !assert_next) : 1'b1;
		RESET_N_OUT_OE <= HAS_RST_N && (!OPEN_DRAIN || assert_next);
		RESET_HIGH_OUT <= HAS_RST_HIGH && assert_next;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic out_asserted;
	assign out_asserted = RESET_HIGH_OUT;

	logic [HW-1:0] low_run_reg;
	always_ff @(posedge CLOCK) begin
		if (RESET || !rst_active) begin
			low_run_reg <= '0;
		end else if (low_run_reg != HW'(HOLD_CYC)) begin
			low_run_reg <= low_run_reg + HW'(1);
		end
	end

	a_hold_min_len: assert property (@(posedge CLOCK) disable iff (RESET)
		$fell(rst_active) |-> $past(low_run_reg) >= HW'(HOLD_CYC - 1))
		else $error("reset released before hold period");

	a_supply_holds: assert property (@(posedge CLOCK) disable iff (RESET)
		SUPPLY_LOW |=> state_reg == srwdg_pkg::RST_CAUSE && hold_reg == '0)
		else $error("supply low did not clear hold timer");

	a_manual_asserts: assert property (@(posedge CLOCK) disable iff (RESET)
		(HAS_MANUAL && !man_clean) |=> out_asserted || !HAS_RST_HIGH)
		else $error("manual reset not asserted");

	a_wd_expiry: assert property (@(posedge CLOCK) disable iff (RESET)
		wd_expire && !cause_now |=> state_reg == srwdg_pkg::RST_HOLD && hold_reg == '0)
		else $error("watchdog expiry did not start hold");

	a_wd_edge_clear: assert property (@(posedge CLOCK) disable iff (RESET)
		kick_edge |=> wd_reg == '0)
		else $error("kick edge did not clear watchdog");

	a_wd_held: assert property (@(posedge CLOCK) disable iff (RESET)
		rst_active |=> wd_reg == '0)
		else $error("watchdog counted during reset");

	a_outputs_inverse: assert property (@(posedge CLOCK) disable iff (RESET)
		(HAS_RST_N && HAS_RST_HIGH && !OPEN_DRAIN) |-> RESET_N_OUT != RESET_HIGH_OUT)
		else $error("reset outputs not complementary");

	a_open_drain: assert property (@(posedge CLOCK) disable iff (RESET)
		(OPEN_DRAIN && HAS_RST_N) |-> RESET_N_OUT_OE == RESET_HIGH_OUT || !HAS_RST_HIGH)
		else $error("open-drain drive outside reset");

	a_release_after: assert property (@(posedge CLOCK) disable iff (RESET)
		state_reg == srwdg_pkg::RST_HOLD && !cause_now && hold_reg == HW'(HOLD_CYC - 1)
		&& !wd_expire |=> state_reg == srwdg_pkg::RST_RUN)
		else $error("reset not released after hold period");

	a_cause_asserts: assert property (@(posedge CLOCK) disable iff (RESET)
		cause_now |=> out_asserted || !HAS_RST_HIGH)
		else $error("reset cause did not assert output");

	a_hold_counts: assert property (@(posedge CLOCK) disable iff (RESET)
		state_reg == srwdg_pkg::RST_HOLD && !cause_now && hold_reg < HW'(HOLD_CYC - 1)
		|=> state_reg == srwdg_pkg::RST_HOLD && hold_reg == $past(hold_reg) + HW'(1))
		else $error("hold timer did not advance");

	a_run_release: assert property (@(posedge CLOCK) disable iff (RESET)
		state_reg == srwdg_pkg::RST_RUN && !cause_now && !wd_expire |=> !out_asserted)
		else $error("reset asserted without a cause");

	a_wd_count: assert property (@(posedge CLOCK) disable iff (RESET)
		!rst_active && !kick_edge && !wd_expire |=> wd_reg == $past(wd_reg) + WW'(1))
		else $error("watchdog did not count while running");

	a_pp_enable: assert property (@(posedge CLOCK) disable iff (RESET)
		(HAS_RST_N && !OPEN_DRAIN) |-> RESET_N_OUT_OE)
		else $error("push-pull output not driven");

	a_od_level: assert property (@(posedge CLOCK) disable iff (RESET)
		(HAS_RST_N && OPEN_DRAIN) |-> !RESET_N_OUT)
		else $error("open-drain output drives high");

	// ----------------------------------------
	// kick path checks
	// ----------------------------------------
	// a pin change passes two sync flops and the filter flop; the edge shows while the previous-level flop still holds the old level
	a_kick_edge_seen: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) && $changed(kick_pin) |-> ##3 kick_edge)
		else $error("kick pin change not detected");

	a_drive_enable: assert property (@(posedge CLOCK) disable iff (RESET)
		!$past(RESET) |-> WATCHDOG_KICK_DRV_OE == (HAS_WATCHDOG && !$past(WATCHDOG_KICK_OE)))
		else $error("kick drive enable wrong");

	a_chain_pulse_on: assert property (@(posedge CLOCK) disable iff (RESET)
		HAS_WATCHDOG && svc_reg == WW'(SVC_AT) |=> WATCHDOG_KICK_DRV)
		else $error("internal kick pulse did not start");

	a_chain_pulse_off: assert property (@(posedge CLOCK) disable iff (RESET)
		svc_reg == WW'(SVC_AT + SVC_LEN) |=> !WATCHDOG_KICK_DRV)
		else $error("internal kick pulse did not end");
endmodule : srwdg_top

`default_nettype wire

// ### tb/srwdg_mcu_model.sv
/*
 * processor-side model: watches the reset output and kicks the watchdog.
 * assumes CLOCK from the bench and a mode set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module srwdg_mcu_model #(
	parameter int unsigned KICK_GAP = 100
) (
	// clock and reset seen
	input  wire logic       clk,
	input  wire logic       rst_seen,
	// 0 released, 1 kicking, 2 stuck low
	input  wire logic [1:0] mode,
	// kick pin drive
	output var  logic       kick,
	output var  logic       kick_oe
);
	int unsigned gap_cnt = 0;
	always @(posedge clk) begin
		kick_oe <= #1 (mode != 2'h0);
		// three-cycle high pulse, 60 ns, just above the shortest legal width
		kick <= #1 (mode == 2'h1) && (gap_cnt >= KICK_GAP - 3);
		if (rst_seen || mode != 2'h1) begin
			gap_cnt <= 0;
		end else begin
			gap_cnt <= (gap_cnt == KICK_GAP - 1) ? 0 : gap_cnt + 1;
		end
	end
endmodule : srwdg_mcu_model

`default_nettype wire

// ### tb/tb_srwdg_top.sv
/*
 * self-checking bench for the reset supervisor, short build timings.
 * assumes the processor model and the design files compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_srwdg_top;
	localparam int HOLD = 20;
	localparam int WD   = 200;
	logic       CLOCK = 1'b0;
	logic       RESET = 1'b1;
	logic       supply_low = 1'b0;
	logic       man_n = 1'b1;
	logic       man_oe = 1'b1;
	logic [1:0] mode = 2'h2;
	wire logic  mcu_kick, mcu_oe, kick_drv, kick_drv_oe, kick_wire;
	wire logic  rst_n, rst_n_oe, rst_high, od_oe, od_n;
	int         bad_count = 0;
	int         check_count = 0;
	int         n;

	always #10 CLOCK = ~CLOCK;
	// released kick line: shows the chain drive when enabled, else no pull, so the inverse of the last value
	assign kick_wire = mcu_oe ? mcu_kick : (kick_drv_oe ? kick_drv : ~mcu_kick);

	srwdg_mcu_model #(.KICK_GAP(100)) u_mcu (.clk(CLOCK), .rst_seen(rst_high),
		.mode(mode), .kick(mcu_kick), .kick_oe(mcu_oe));
	srwdg_top #(.HOLD_CYC(HOLD), .WD_CYC(WD), .DEBOUNCE_CYC(4)) DUT (.CLOCK(CLOCK),
		.RESET(RESET), .SUPPLY_LOW(supply_low), .MANUAL_RESET_N(man_n),
		.MANUAL_RESET_N_OE(man_oe), .WATCHDOG_KICK(kick_wire), .WATCHDOG_KICK_OE(mcu_oe),
		.WATCHDOG_KICK_DRV(kick_drv), .WATCHDOG_KICK_DRV_OE(kick_drv_oe),
		.RESET_N_OUT(rst_n), .RESET_N_OUT_OE(rst_n_oe), .RESET_HIGH_OUT(rst_high));
	srwdg_top #(.HOLD_CYC(HOLD), .WD_CYC(WD), .DEBOUNCE_CYC(4), .OPEN_DRAIN(1'b1)) DUT_OD (
		.CLOCK(CLOCK), .RESET(RESET), .SUPPLY_LOW(supply_low), .MANUAL_RESET_N(man_n),
		.MANUAL_RESET_N_OE(man_oe), .WATCHDOG_KICK(kick_wire), .WATCHDOG_KICK_OE(mcu_oe),
		.WATCHDOG_KICK_DRV(), .WATCHDOG_KICK_DRV_OE(), .RESET_N_OUT(od_n),
		.RESET_N_OUT_OE(od_oe), .RESET_HIGH_OUT());

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic final_report;
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic check_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check_bit

	task automatic check_range(input int got, input int lo, input int hi, input string what);
		check_count++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("unexpected at %0t: %s count %0d", $time, what, got);
		end
	endtask : check_range

	task automatic step(input int k);
		repeat (k) @(posedge CLOCK);
		#1;
	endtask : step

	task automatic wait_rise(output int k, input int lim);
		k = 0;
		while (rst_high !== 1'b1 && k < lim) begin
			step(1);
			k++;
		end
		check_range(k, 0, lim - 1, "reset never rose");
		if (k >= lim) final_report;
	endtask : wait_rise

	task automatic hold_len(output int k);
		k = 0;
		while (rst_high === 1'b1 && k < 2000) begin
			step(1);
			k++;
		end
		check_range(k, 0, 1999, "reset never fell");
		if (k >= 2000) final_report;
	endtask : hold_len

	task automatic quiet(input int cyc, output int hits);
		hits = 0;
		repeat (cyc) begin
			step(1);
			if (rst_high !== 1'b0) hits++;
		end
	endtask : quiet

	// settled mid-cycle, both outputs against each other every cycle
	always @(negedge CLOCK) begin
		if (!RESET) begin
			check_bit(rst_high, ~rst_n, "high output not inverse of low");
			check_bit(od_oe, rst_high, "open-drain sink differs from reset");
			check_bit(rst_n_oe, 1'b1, "push-pull low output released");
			check_bit(od_n, 1'b0, "open-drain output drives high");
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_watchdog;
		hold_len(n);
		check_range(n, HOLD, HOLD + 10, "power-on hold");
		wait_rise(n, WD + 20);
		check_range(n, WD - 2, WD + 6, "stuck kick expiry");
		hold_len(n);
		check_range(n, HOLD, HOLD + 10, "expiry hold");
		wait_rise(n, WD + 20);
		check_range(n, WD - 2, WD + 6, "timer restarts after release");
		mode = 2'h1;
		hold_len(n);
		quiet(3 * WD, n);
		check_range(n, 0, 0, "kicked watchdog expired");
	endtask : s_watchdog

	task automatic s_supply;
		supply_low = 1'b1;
		step(1);
		supply_low = 1'b0;
		wait_rise(n, 5);
		hold_len(n);
		check_range(n, HOLD, HOLD + 10, "one-cycle supply dip");
		supply_low = 1'b1;
		step(1);
		supply_low = 1'b0;
		step(HOLD / 2);
		supply_low = 1'b1;
		step(3);
		supply_low = 1'b0;
		hold_len(n);
		check_range(n, HOLD, HOLD + 10, "hold restarted by dip");
	endtask : s_supply

	task automatic s_manual;
		man_n = 1'b0;
		step(2);
		man_n = 1'b1;
		step(1);
		man_n = 1'b0;
		step(12);
		check_bit(rst_high, 1'b1, "manual low no reset");
		man_n = 1'b1;
		step(1);
		man_n = 1'b0;
		step(1);
		man_n = 1'b1;
		hold_len(n);
		check_range(n, HOLD, HOLD + 16, "manual release hold");
		quiet(40, n);
		check_range(n, 0, 0, "bounce gave second reset");
		man_oe = 1'b0;
		man_n = 1'b0;
		quiet(40, n);
		check_range(n, 0, 0, "floating manual pin reset");
		man_oe = 1'b1;
		man_n = 1'b1;
	endtask : s_manual

	task automatic s_float;
		int   pulses;
		int   hits;
		logic prev;
		pulses = 0;
		hits = 0;
		mode = 2'h0;
		repeat (3 * WD) begin
			prev = kick_drv;
			step(1);
			if (prev === 1'b0 && kick_drv === 1'b1) pulses++;
			if (rst_high !== 1'b0) hits++;
		end
		check_range(hits, 0, 0, "floating kick reset during run");
		check_bit(kick_drv_oe, 1'b1, "chain not driving kick");
		check_range(pulses, 2, 4, "chain pulses");
		check_bit(rst_high, 1'b0, "floating kick reset");
	endtask : s_float

	initial begin
		step(4);
		RESET = 1'b0;
		s_watchdog;
		s_supply;
		s_manual;
		s_float;
		final_report;
	end
endmodule : tb_srwdg_top

`default_nettype wire
